// ---- verilog/tts_pkg.sv ----
// package: constants, rate codes, register map and stream word of the telemetry train simulator
package tts_pkg;

    // base clock and system clock
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned BASE_CLOCK_HZ = 400;
    localparam int unsigned BASE_TICK_CYCLES = CLK_HZ / BASE_CLOCK_HZ;

    // counter sizes
    localparam int unsigned RATE_COUNTER_STAGES = 7;
    localparam int unsigned SYNC_DIVIDER_STAGES = 4;
    localparam int unsigned FRAME_COUNTER_STAGES = 4;

    // counter stages picked as fundamental gate
    localparam logic [2:0] STAGE_FAST = 3'h0;
    localparam logic [2:0] STAGE_MID = 3'h2;
    localparam logic [2:0] STAGE_NORMAL = 3'h6;

    // register byte offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] TRIM_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;
    localparam logic [3:0] COUNT_OFFSET = 4'hc;

    // control fields
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_RATE_LSB = 1;
    localparam int unsigned CTRL_SOURCE_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // tone period in clock cycles, reset value and smallest value used
    localparam logic [15:0] TRIM_RESET = 16'h0040;
    localparam logic [15:0] TRIM_MIN = 16'h0002;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // bit_rate_select codes: normal 3.125 cps, accelerated 50 and 200 cps
    typedef enum logic [1:0] {
        TTS_RATE_NORMAL,
        TTS_RATE_MID,
        TTS_RATE_FAST,
        TTS_RATE_SPARE
    } tts_rate_e;

    // one word of the simulated stream
    typedef struct packed {
        logic data_pulse;
        logic osc_gate;
        logic base_gate_signal;
        logic stretched_gate_signal;
        logic frame_sync_marker;
        logic sequence_start_marker;
    } tts_sample_s;

endpackage : tts_pkg

// ---- verilog/tts_tone_gen.sv ----
// gated oscillator model: programmable divider with period boundary strobe
`timescale 1ns/10ps

module tts_tone_gen (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [15:0] period,
    output logic tone,
    output logic boundary
);

    logic [15:0] phase;
    logic [15:0] last;

    // periods below two cycles would stall the boundary strobe
    assign last = (period < tts_pkg::TRIM_MIN) ? (tts_pkg::TRIM_MIN - 16'h0001) : (period - 16'h0001);

    // phase counter, frozen while the block stalls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 16'h0000;
        end else if (run) begin
            phase <= (phase >= last) ? 16'h0000 : phase + 16'h0001;
        end
    end

    // tone is high in the first half of each period
    assign tone = (phase < {1'b0, last[15:1]} + 16'h0001);
    assign boundary = run && (phase >= last);

endmodule : tts_tone_gen

// ---- verilog/tts_train_sim.sv ----
// top: telemetry train simulator with axi4-lite registers and buffered sample stream
//
// What this block does
// R1: a 400 cps tick clocks a seven-stage counter feeding every bit-rate gate.
// R2: bit_rate_select picks counter stage 2^0, 2^2 or 2^6 as fundamental gate.
// R3: three rates: 3.125 cps normal, 50 and 200 cps accelerated.
// R4: the gating signal drives the oscillator gate flip-flop, 50 percent duty.
// R5: data pulses are oscillator pulses, present only while the gate is open.
// R6: every 16th burst is widened to 75 percent duty to mimic sync.
// R7: fundamental gate feeds the OR as base_gate_signal and clocks a divide-by-16.
// R8: delayed divide-by-16 output forms stretched_gate_signal; the OR drives the gate.
// R9: every 16th OR output gate lasts one and a half fundamental durations.
// R10: three fixed stretch delays, one per rate, chosen by bit_rate_select.
// R11: the gate flip-flop changes only at oscillator period boundaries.
// R12: marker signal combines base and stretched gates, gated by a frame counter.
// R13: stretched gate clocks the frame counter; its 2^0 bit yields alternate frame-sync.
// R14: frame counter all zero with marker gives sequence_start_marker at frame zero.
// R15: downstream timing uses the simulated frame-sync instead of its own recognition.
// R16: in test_source_mode the frame sorter resets on sequence_start_marker.
// R17: in test_source_mode the downstream frame-corrector matrix is inhibited.
// R18: reset clears counters and gate; generation starts at frame zero, gate closed.
// R19: oscillator is a programmable divider; tone_frequency_trim is a register value.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module tts_train_sim #(
    parameter int unsigned BASE_TICK_CYCLES = tts_pkg::BASE_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output tts_pkg::tts_sample_s m_sample,
    output logic m_valid,
    input wire logic m_ready,
    output logic test_source_mode
);

    // maps a rate code to the counter stage used as fundamental gate
    function automatic logic [2:0] stage_of(input logic [1:0] rate);
        case (rate)
            2'(tts_pkg::TTS_RATE_MID): stage_of = tts_pkg::STAGE_MID;
            2'(tts_pkg::TTS_RATE_FAST): stage_of = tts_pkg::STAGE_FAST;
            default: stage_of = tts_pkg::STAGE_NORMAL;
        endcase
    endfunction : stage_of

    // stretch delay: half the fundamental high time, in clock cycles
    function automatic logic [31:0] stretch_cycles(input logic [2:0] stage);
        logic [31:0] high_time;
        high_time = 32'(BASE_TICK_CYCLES) << stage;
        stretch_cycles = (high_time >> 1) == 32'h0 ? 32'h1 : (high_time >> 1);
    endfunction : stretch_cycles

    // register state
    logic [3:0] ctrl;
    logic [15:0] tone_frequency_trim;
    logic [1:0] bit_rate_select;
    logic gen_enable;
    logic input_source_select;

    // generator state
    logic run;
    logic [31:0] tick_count;
    logic base_tick;
    logic [6:0] rate_count;
    logic [2:0] gate_stage;
    logic base_gate_signal;
    logic base_gate_q;
    logic [3:0] sync_div;
    logic [31:0] stretch_left;
    logic stretch_start;
    logic stretched_gate_signal;
    logic stretched_q;
    logic [3:0] frame_count;
    logic gate_request;
    logic osc_gate;
    logic tone;
    logic tone_boundary;
    logic marker;
    tts_pkg::tts_sample_s sample;
    tts_pkg::tts_sample_s last_pushed;

    // buffer state
    logic head_valid;
    logic tail_valid;
    tts_pkg::tts_sample_s tail_data;
    logic buf_in_ready;
    logic push;
    logic pop;

    // axi state
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic do_write;

    assign gen_enable = ctrl[tts_pkg::CTRL_ENABLE_BIT];
    assign bit_rate_select = ctrl[tts_pkg::CTRL_RATE_LSB +: 2];
    assign input_source_select = ctrl[tts_pkg::CTRL_SOURCE_BIT];

    // generation freezes while the buffer is full, so a stalled receiver loses no word
    assign buf_in_ready = !tail_valid;
    assign run = gen_enable && buf_in_ready;

    // 400 cps base tick from the system clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_count <= 32'h0;
        end else if (run) begin
            tick_count <= (tick_count >= 32'(BASE_TICK_CYCLES) - 32'h1) ? 32'h0 : tick_count + 32'h1;
        end
    end
    assign base_tick = run && (tick_count >= 32'(BASE_TICK_CYCLES) - 32'h1);

    // seven-stage binary counter clocked by the base tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rate_count <= 7'h00; // [R18]
        end else if (base_tick) begin
            rate_count <= rate_count + 7'h01; // [R1]
        end
    end

    // fundamental gate: stage 2^6 gives 3.125 cps, 2^2 gives 50, 2^0 gives 200
    assign gate_stage = stage_of(bit_rate_select); // [R2] [R3]
    assign base_gate_signal = rate_count[gate_stage]; // [R1] [R7]

    // edge history for the internal gate signals
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_gate_q <= 1'b0;
            stretched_q <= 1'b0;
        end else if (run) begin
            base_gate_q <= base_gate_signal;
            stretched_q <= stretched_gate_signal;
        end
    end

    // divide-by-16 counter clocked by rising edges of the fundamental gate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_div <= 4'h0; // [R18]
        end else if (run && base_gate_signal && !base_gate_q) begin
            sync_div <= sync_div + 4'h1; // [R7]
        end
    end

    // the 16th fundamental gate falls now; the stretch starts in this cycle so the or output has no gap
    assign stretch_start = !base_gate_signal && base_gate_q && (sync_div == 4'h0);

    // delay stage: after the 16th fundamental gate falls, hold the second or input for half a gate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stretch_left <= 32'h0;
        end else if (run) begin
            if (stretch_start) begin
                stretch_left <= stretch_cycles(gate_stage) - 32'h1; // [R8] [R10]
            end else if (stretch_left != 32'h0) begin
                stretch_left <= stretch_left - 32'h1;
            end
        end
    end
    assign stretched_gate_signal = stretch_start || (stretch_left != 32'h0); // [R8]

    // or of both inputs: 1.5 times the gate every 16th burst, 75 percent duty
    assign gate_request = base_gate_signal || stretched_gate_signal; // [R6] [R9]

    // oscillator model, divider period set by tone_frequency_trim
    tts_tone_gen u_tone (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .period(tone_frequency_trim), // [R19]
        .tone(tone),
        .boundary(tone_boundary)
    );

    // gate flip-flop moves only at the end of a tone period, so no pulse is ever cut short
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_gate <= 1'b0; // [R18]
        end else if (tone_boundary) begin
            osc_gate <= gate_request; // [R4] [R11]
        end
    end

    // frame counter clocked by the end of each stretched gate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_count <= 4'h0; // [R18]
        end else if (run && !stretched_gate_signal && stretched_q) begin
            frame_count <= frame_count + 4'h1; // [R13]
        end
    end

    // marker matrix: marker is the stretched tail beyond the fundamental gate
    assign marker = stretched_gate_signal && !base_gate_signal; // [R12]

    // assemble the current stream word
    always_comb begin
        sample.data_pulse = osc_gate && tone; // [R5]
        sample.osc_gate = osc_gate;
        sample.base_gate_signal = base_gate_signal;
        sample.stretched_gate_signal = stretched_gate_signal;
        sample.frame_sync_marker = marker && frame_count[0]; // [R13] [R15]
        sample.sequence_start_marker = marker && (frame_count == 4'h0); // [R14] [R16]
    end

    // a word is pushed whenever the sample changes; the buffer never sees a repeat
    assign push = gen_enable && buf_in_ready && (sample != last_pushed);
    assign pop = head_valid && m_ready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_pushed <= '0;
        end else if (push) begin
            last_pushed <= sample;
        end
    end

    // two-entry buffer: head feeds the output port, tail absorbs one word of stall
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            head_valid <= 1'b0;
            tail_valid <= 1'b0;
            m_sample <= '0;
            tail_data <= '0;
        end else if (pop && tail_valid) begin
            m_sample <= tail_data;
            tail_valid <= 1'b0;
        end else if (pop) begin
            head_valid <= push;
            if (push) begin
                m_sample <= sample;
            end
        end else if (push && !head_valid) begin
            head_valid <= 1'b1;
            m_sample <= sample;
        end else if (push) begin
            tail_valid <= 1'b1;
            tail_data <= sample;
        end
    end
    assign m_valid = head_valid;

    // axi write side: address and data are taken in either order and held
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_awready <= !next_aw_held;
            s_axi_wready <= !next_w_held;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= tts_pkg::CTRL_RESET;
            tone_frequency_trim <= tts_pkg::TRIM_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tts_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= tts_pkg::RESP_OKAY;
            case (aw_addr)
                tts_pkg::CTRL_OFFSET: begin
                    if (w_strb[0]) begin
                        ctrl <= w_data[3:0];
                    end
                end
                tts_pkg::TRIM_OFFSET: begin
                    if (w_strb[0]) begin
                        tone_frequency_trim[7:0] <= w_data[7:0];
                    end
                    if (w_strb[1]) begin
                        tone_frequency_trim[15:8] <= w_data[15:8];
                    end
                end
                tts_pkg::STATUS_OFFSET, tts_pkg::COUNT_OFFSET: begin
                    s_axi_bresp <= tts_pkg::RESP_OKAY; // read-only, write ignored
                end
                default: begin
                    s_axi_bresp <= tts_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // axi read side: one read at a time, data registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= tts_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= tts_pkg::RESP_OKAY;
            case (s_axi_araddr)
                tts_pkg::CTRL_OFFSET: s_axi_rdata <= {28'h0, ctrl};
                tts_pkg::TRIM_OFFSET: s_axi_rdata <= {16'h0, tone_frequency_trim};
                tts_pkg::STATUS_OFFSET: begin
                    s_axi_rdata <= {16'h0, frame_count, sync_div, 2'h0, tail_valid, head_valid,
                                    stretched_gate_signal, base_gate_signal, osc_gate, tone};
                end
                tts_pkg::COUNT_OFFSET: s_axi_rdata <= {25'h0, rate_count};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= tts_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // mode pin to the frame sorter and frame-corrector of the downstream logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_source_mode <= 1'b0;
        end else begin
            test_source_mode <= input_source_select; // [R16] [R17]
        end
    end

endmodule : tts_train_sim

// ---- sim/tts_train_sim_chk.sv ----
// checker: bus handshake and stream relations seen at the simulator's ports
`timescale 1ns/10ps

module tts_train_sim_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tts_pkg::tts_sample_s m_sample,
    input wire logic m_valid,
    input wire logic m_ready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // write address and data taken on one edge, then a hold cycle before the answer
    sequence wr_both_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take_s;
        s_axi_arvalid && s_axi_arready;
    endsequence

    wr_answer_a: assert property (wr_both_s |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two edges after the take");
    rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one edge after the take");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    // a stalled word must stand, otherwise the far side loses it
    stall_hold_a: assert property (m_valid && !m_ready |=> m_valid && $stable(m_sample))
        else $error("stream word changed while stalled");
    pulse_gate_a: assert property (m_valid && m_sample.data_pulse |-> m_sample.osc_gate)
        else $error("data pulse outside open gate");
    no_overlap_a: assert property (m_valid |-> !(m_sample.stretched_gate_signal && m_sample.base_gate_signal))
        else $error("stretch overlaps fundamental gate");
    sync_mark_a: assert property (m_valid && m_sample.frame_sync_marker |-> m_sample.stretched_gate_signal && !m_sample.base_gate_signal)
        else $error("frame sync outside marker window");
    seq_mark_a: assert property (m_valid && m_sample.sequence_start_marker |-> m_sample.stretched_gate_signal && !m_sample.frame_sync_marker)
        else $error("sequence marker outside frame zero marker");
endmodule : tts_train_sim_chk

bind tts_train_sim tts_train_sim_chk i_tts_train_sim_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .m_sample, .m_valid, .m_ready
);

// ---- sim/tts_sorter_model.sv ----
// far-side model: frame sorter taking the simulated stream, with stalls
`timescale 1ns/10ps

module tts_sorter_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire tts_pkg::tts_sample_s sample,
    input wire logic valid,
    output logic ready,
    input wire logic stall_en,
    input wire logic test_mode,
    output logic corr_inhibit,
    output logic [15:0] n_seq,
    output logic [15:0] n_base,
    output logic [15:0] last_sync,
    output logic [15:0] last_base,
    output logic [15:0] last_pulse
);
    tts_pkg::tts_sample_s prev;
    logic [4:0] tick;
    logic [15:0] run_sync, run_base, run_pulse;
    logic take, r_base, r_sync, r_seq, r_pulse;

    // rising edges seen between consecutive taken words
    assign take = valid && ready;
    assign r_base = take && sample.base_gate_signal && !prev.base_gate_signal;
    assign r_sync = take && sample.frame_sync_marker && !prev.frame_sync_marker;
    assign r_seq = take && sample.sequence_start_marker && !prev.sequence_start_marker;
    assign r_pulse = take && sample.data_pulse && !prev.data_pulse;
    assign corr_inhibit = test_mode;

    // stall ten of every 32 cycles: long enough to fill the two-entry buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick <= 5'h0;
            ready <= 1'b0;
        end else begin
            tick <= tick + 5'h1;
            ready <= !(stall_en && tick < 5'h0a);
        end
    end

    // sorter restarts its sequence on the frame zero marker in test mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= '0;
            {n_seq, n_base, last_sync, last_base, last_pulse} <= '0;
            {run_sync, run_base, run_pulse} <= '0;
        end else begin
            if (take) prev <= sample;
            n_base <= n_base + 16'(r_base);
            if (r_seq && test_mode) begin
                n_seq <= n_seq + 16'h1;
                {last_sync, last_base, last_pulse} <= {run_sync, run_base, run_pulse};
                {run_sync, run_base, run_pulse} <= '0;
            end else begin
                run_sync <= run_sync + 16'(r_sync);
                run_base <= run_base + 16'(r_base);
                run_pulse <= run_pulse + 16'(r_pulse);
            end
        end
    end
endmodule : tts_sorter_model

// ---- sim/tb_top.sv ----
// testbench: register access, sync sequence and bit rate checks of the simulator
`timescale 1ns/10ps

module tb_top;
    localparam int unsigned TICK = 8;
    localparam logic [1:0] OK = tts_pkg::RESP_OKAY;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic stall_en = 1'b0;
    // slow: answer ready raised only once the response is seen, so the slave must hold it
    logic slow = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    tts_pkg::tts_sample_s m_sample;
    logic m_valid, m_ready, test_source_mode;
    logic [15:0] n_seq, n_base, last_sync, last_base, last_pulse;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int k, st, e, d, b0;

    tts_train_sim #(.BASE_TICK_CYCLES(TICK)) i_tts_train_sim (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .m_sample, .m_valid, .m_ready, .test_source_mode
    );
    tts_sorter_model i_tts_sorter_model (
        .aclk, .aresetn, .sample(m_sample), .valid(m_valid), .ready(m_ready), .stall_en,
        .test_mode(test_source_mode), .corr_inhibit(), .n_seq, .n_base, .last_sync,
        .last_base, .last_pulse
    );

    always #2 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] dat, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow;
        // no wait limit here: only the bench timeout ends a hung write
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, ex);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // whole run needs some 22000 cycles; a hang is cut off well above that
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 32'h0, OK);
        rd(4'h4, 32'h40, OK);
        rd(4'h8, 32'h1, OK); // tone stands high in the first half period, gate closed
        rd(4'hc, 32'h0, OK);
        rd(4'h2, 32'h0, tts_pkg::RESP_SLVERR);
        chk("m_valid", {31'h0, m_valid}, 32'h0);
        $display("test reset values done");
        // fastest rate with a short tone period, far side stalling
        slow = 1'b1;
        wr(4'h4, 32'h2, OK);
        rd(4'h4, 32'h2, OK);
        slow = 1'b0;
        stall_en <= 1'b1;
        wr(4'h0, 32'hd, OK);
        repeat (2) @(posedge aclk);
        chk("test mode", {31'h0, test_source_mode}, 32'h1);
        for (k = 0; k < 30000 && n_seq < 16'h2; k++) @(posedge aclk);
        chk("syncs per sequence", {16'h0, last_sync}, 32'h8);
        chk("gates per sequence", {16'h0, last_base}, 32'h100);
        chk("pulses present", {31'h0, last_pulse >= 16'h100}, 32'h1);
        $display("test sync sequence done");
        // every rate code, free flow, rising gates counted over a fixed window
        stall_en <= 1'b0;
        for (k = 0; k < 4; k++) begin
            wr(4'h0, 32'h9 | (32'(k) << 1), OK);
            st = (k == 2) ? 0 : (k == 1) ? 2 : 6;
            e = 4096 / (2 * TICK * (1 << st));
            b0 = int'(n_base);
            repeat (4096) @(posedge aclk);
            d = int'(n_base) - b0;
            chk("gate rate", 32'((d + 1 >= e) && (d <= e + 1)), 32'h1);
        end
        $display("test bit rates done");
        end_of_test();
    end
endmodule : tb_top
